// File: pkg/stack_pop_map.svh
// constants for the stack pop instruction unit
`ifndef STACK_POP_MAP_SVH
`define STACK_POP_MAP_SVH
`define OPC_POP_BYTE_LONG_DIRECT 8'h76
`define OPC_POP_ACC_PAIR 8'h70
`define OPC_POP_STATUS_WORD 8'h90
`define OPC_POP_WORD_INDIRECT 8'h37
`define LEN_POP_BYTE_LONG_DIRECT 16'h0003
`define LEN_POP_ACC_PAIR 16'h0001
`define LEN_POP_STATUS_WORD 16'h0001
`define LEN_POP_WORD_INDIRECT 16'h0002
`define CYC_POP_BYTE_LONG_DIRECT 2'h2
`define CYC_POP_ACC_PAIR 2'h2
`define CYC_POP_STATUS_WORD 2'h1
`define CYC_POP_WORD_INDIRECT 2'h3
`define NINTH_BIT_POS 8
`define NINTH_BIT_STATUS_FLAG_POS 1
`define SP_RESET 16'h0000
`define PC_RESET 16'h0000
`define STATUS_WORD_RESET 8'h00
`define BA_RESET 16'h0000
`endif

// File: pkg/stack_pop_pkg.sv
// types shared by the stack pop instruction unit
package stack_pop_pkg;
  typedef enum logic [1:0] {
    POP_KIND_BYTE_LONG,
    POP_KIND_ACC_PAIR,
    POP_KIND_STATUS_WORD,
    POP_KIND_WORD_INDIRECT
  } pop_kind_e;
  typedef struct packed {
    logic start;
    logic [7:0] opcode;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } instr_req_s;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [8:0] wdata;
  } mem_req_s;
  typedef struct packed {
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] program_status_word;
    logic [15:0] ba;
  } arch_state_s;
endpackage : stack_pop_pkg

// File: core/stack_pop_instruction_unit.sv
// decode and execution of four stack pop instructions
`timescale 1ns/100ps
`include "stack_pop_map.svh"

module stack_pop_instruction_unit
  import stack_pop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire instr_req_s instrReq,
  input wire logic archLoad,
  input wire arch_state_s archLoadValue,
  input wire logic [8:0] memRdata,
  output mem_req_s memReq,
  output arch_state_s archState,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [1:0] cyclesUsed
);
  typedef enum logic [3:0] {
    IDLE, PTR_LO, PTR_HI, RD_LO, RD_HI, CAP_HI, WR_HI, RD_BYTE, CAP_BYTE, FINISH
  } seq_state_e;

  seq_state_e state_reg;
  pop_kind_e kind_reg;
  logic [15:0] dst_reg;
  logic [5:0] pairIndex_reg;
  logic [8:0] lo_reg;
  logic [8:0] hi_reg;
  logic flag_reg;
  logic decodeOk;
  pop_kind_e decodeKind;

  always_comb begin
    decodeOk = 1'b1;
    decodeKind = POP_KIND_BYTE_LONG;
    case (instrReq.opcode)
      `OPC_POP_BYTE_LONG_DIRECT: decodeKind = POP_KIND_BYTE_LONG;
      `OPC_POP_ACC_PAIR: decodeKind = POP_KIND_ACC_PAIR;
      `OPC_POP_STATUS_WORD: decodeKind = POP_KIND_STATUS_WORD;
      `OPC_POP_WORD_INDIRECT: begin
        decodeKind = POP_KIND_WORD_INDIRECT;
        // other second-byte forms belong to different pops and are refused
        decodeOk = !instrReq.operand1[7] && !instrReq.operand1[0];
      end
      default: decodeOk = 1'b0;
    endcase
  end

  // sequencer and memory requests; reads return data one cycle after rd
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= IDLE;
      kind_reg <= POP_KIND_BYTE_LONG;
      dst_reg <= 16'h0000;
      pairIndex_reg <= 6'h00;
      memReq <= '0;
    end else if (ce) begin
      memReq <= '0;
      case (state_reg)
        IDLE: begin
          if (instrReq.start && decodeOk) begin
            kind_reg <= decodeKind;
            dst_reg <= {instrReq.operand2, instrReq.operand1};
            pairIndex_reg <= instrReq.operand1[6:1];
            memReq.rd <= 1'b1;
            case (decodeKind)
              POP_KIND_WORD_INDIRECT: begin
                // the pointer pair lives in ram at twice its index
                memReq.addr <= {9'h000, instrReq.operand1[6:1], 1'b0};
                state_reg <= PTR_LO;
              end
              POP_KIND_ACC_PAIR: begin
                memReq.addr <= archState.sp - 16'h0001;
                state_reg <= RD_LO;
              end
              default: begin
                memReq.addr <= archState.sp;
                state_reg <= RD_BYTE;
              end
            endcase
          end
        end
        PTR_LO: begin
          memReq.rd <= 1'b1;
          memReq.addr <= {9'h000, pairIndex_reg, 1'b1};
          state_reg <= PTR_HI;
        end
        PTR_HI: begin
          dst_reg[7:0] <= memRdata[7:0];
          memReq.rd <= 1'b1;
          memReq.addr <= archState.sp - 16'h0001;
          state_reg <= RD_LO;
        end
        RD_LO: begin
          if (kind_reg == POP_KIND_WORD_INDIRECT) begin
            dst_reg[15:8] <= memRdata[7:0];
          end
          memReq.rd <= 1'b1;
          memReq.addr <= archState.sp;
          state_reg <= RD_HI;
        end
        RD_HI: state_reg <= CAP_HI;
        CAP_HI: begin
          if (kind_reg == POP_KIND_WORD_INDIRECT) begin
            memReq.wr <= 1'b1;
            memReq.addr <= dst_reg;
            memReq.wdata <= lo_reg;
            state_reg <= WR_HI;
          end else begin
            state_reg <= FINISH;
          end
        end
        WR_HI: begin
          memReq.wr <= 1'b1;
          memReq.addr <= dst_reg + 16'h0001;
          memReq.wdata <= hi_reg;
          state_reg <= FINISH;
        end
        RD_BYTE: state_reg <= CAP_BYTE;
        CAP_BYTE: begin
          if (kind_reg == POP_KIND_BYTE_LONG) begin
            // all nine bits go out; a target without a ninth bit drops it
            memReq.wr <= 1'b1;
            memReq.addr <= dst_reg;
            memReq.wdata <= memRdata;
          end
          state_reg <= FINISH;
        end
        FINISH: state_reg <= IDLE;
        default: state_reg <= IDLE;
      endcase
    end
  end

  // popped data capture and the ninth-bit flag value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lo_reg <= 9'h000;
      hi_reg <= 9'h000;
      flag_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        RD_HI: lo_reg <= memRdata;
        CAP_HI: begin
          hi_reg <= memRdata;
          flag_reg <= memRdata[`NINTH_BIT_POS];
        end
        CAP_BYTE: begin
          lo_reg <= memRdata;
          if (kind_reg == POP_KIND_STATUS_WORD) begin
            flag_reg <= memRdata[`NINTH_BIT_STATUS_FLAG_POS];
          end else begin
            flag_reg <= memRdata[`NINTH_BIT_POS];
          end
        end
        default: ;
      endcase
    end
  end

  // architectural registers; a load from the core wins only when idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      archState.sp <= `SP_RESET;
      archState.pc <= `PC_RESET;
      archState.program_status_word <= `STATUS_WORD_RESET;
      archState.ba <= `BA_RESET;
    end else if (ce) begin
      if (state_reg == IDLE && archLoad) begin
        archState <= archLoadValue;
      end else if (state_reg == FINISH) begin
        case (kind_reg)
          POP_KIND_BYTE_LONG: begin
            archState.sp <= archState.sp - 16'h0001;
            archState.pc <= archState.pc + `LEN_POP_BYTE_LONG_DIRECT;
            archState.program_status_word[`NINTH_BIT_STATUS_FLAG_POS] <= flag_reg;
          end
          POP_KIND_ACC_PAIR: begin
            archState.sp <= archState.sp - 16'h0002;
            archState.pc <= archState.pc + `LEN_POP_ACC_PAIR;
            archState.ba <= {hi_reg[7:0], lo_reg[7:0]};
            archState.program_status_word[`NINTH_BIT_STATUS_FLAG_POS] <= flag_reg;
          end
          POP_KIND_STATUS_WORD: begin
            archState.sp <= archState.sp - 16'h0001;
            archState.pc <= archState.pc + `LEN_POP_STATUS_WORD;
            archState.program_status_word <= {lo_reg[7:2], flag_reg, lo_reg[0]};
          end
          default: begin
            archState.sp <= archState.sp - 16'h0002;
            archState.pc <= archState.pc + `LEN_POP_WORD_INDIRECT;
            archState.program_status_word[`NINTH_BIT_STATUS_FLAG_POS] <= flag_reg;
          end
        endcase
      end
    end
  end

  // status toward the core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      cyclesUsed <= 2'h0;
    end else if (ce) begin
      done <= state_reg == FINISH;
      illegal <= state_reg == IDLE && instrReq.start && !decodeOk;
      if (state_reg == IDLE && instrReq.start && decodeOk) begin
        busy <= 1'b1;
      end else if (state_reg == FINISH) begin
        busy <= 1'b0;
      end
      if (state_reg == FINISH) begin
        case (kind_reg)
          POP_KIND_BYTE_LONG: cyclesUsed <= `CYC_POP_BYTE_LONG_DIRECT;
          POP_KIND_ACC_PAIR: cyclesUsed <= `CYC_POP_ACC_PAIR;
          POP_KIND_STATUS_WORD: cyclesUsed <= `CYC_POP_STATUS_WORD;
          default: cyclesUsed <= `CYC_POP_WORD_INDIRECT;
        endcase
      end
    end
  end
endmodule : stack_pop_instruction_unit

// File: bench/stack_pop_instruction_unit_props.sv
// timing checker for the stack pop instruction unit
`timescale 1ns/100ps
module stack_pop_instruction_unit_props
  import stack_pop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire instr_req_s instrReq,
  input wire logic archLoad,
  input wire arch_state_s archLoadValue,
  input wire logic [8:0] memRdata,
  input wire mem_req_s memReq,
  input wire arch_state_s archState,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic [1:0] cyclesUsed
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // accepted also in the done cycle, so back-to-back starts count
  wire logic acc = ce && instrReq.start && (!busy || done);
  wire logic [7:0] op = instrReq.opcode;
  wire logic ind = acc && op == 8'h37 && !instrReq.operand1[7] && !instrReq.operand1[0];
  property p_rd_long;
    acc && op == 8'h76 |=> memReq.rd && memReq.addr == $past(archState.sp);
  endproperty
  a_rd_long: assert property (p_rd_long) else $error("long pop read");
  property p_wr_long;
    acc && op == 8'h76 |-> ##3 memReq.wr
      && memReq.addr == {$past(instrReq.operand2, 3), $past(instrReq.operand1, 3)};
  endproperty
  a_wr_long: assert property (p_wr_long) else $error("long pop write");
  property p_done_long;
    acc && op == 8'h76 |-> ##4 done && cyclesUsed == 2'h2;
  endproperty
  a_done_long: assert property (p_done_long) else $error("long pop timing");
  property p_rd_pair;
    acc && op == 8'h70 |-> ##1 memReq.rd && memReq.addr == $past(archState.sp) - 16'h1
      ##1 memReq.rd && memReq.addr == $past(archState.sp, 2);
  endproperty
  a_rd_pair: assert property (p_rd_pair) else $error("pair pop reads");
  property p_sp_pair;
    acc && op == 8'h70 |-> ##5 done && archState.sp == $past(archState.sp, 5) - 16'h2;
  endproperty
  a_sp_pair: assert property (p_sp_pair) else $error("pair pop stack");
  property p_status;
    acc && op == 8'h90 |-> ##4 done && cyclesUsed == 2'h1 && !$past(memReq.wr);
  endproperty
  a_status: assert property (p_status) else $error("status pop");
  property p_ind;
    ind |-> ##6 memReq.wr ##1 memReq.wr && memReq.addr == $past(memReq.addr) + 16'h1
      ##1 done && cyclesUsed == 2'h3;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect pop");
  property p_bad;
    acc && op == 8'h37 && (instrReq.operand1[7] || instrReq.operand1[0]) |=> illegal && !busy;
  endproperty
  a_bad: assert property (p_bad) else $error("bad second byte taken");
  property p_busy_long;
    acc && op == 8'h76 |=> busy [*3] ##1 !busy && done;
  endproperty
  a_busy_long: assert property (p_busy_long) else $error("long pop busy span");
endmodule : stack_pop_instruction_unit_props

bind stack_pop_instruction_unit stack_pop_instruction_unit_props u_props (.clk(clk),
  .reset(reset), .ce(ce), .instrReq(instrReq), .archLoad(archLoad),
  .archLoadValue(archLoadValue), .memRdata(memRdata), .memReq(memReq),
  .archState(archState), .busy(busy), .done(done), .illegal(illegal),
  .cyclesUsed(cyclesUsed));

// File: bench/tb_stack_pop_instruction_unit.sv
// self-checking bench for the stack pop instruction unit
`timescale 1ns/100ps
module tb_stack_pop_instruction_unit
  import stack_pop_pkg::*;
;
  logic clk, reset, ce, archLoad, busy, done, illegal;
  logic [1:0] cyclesUsed;
  logic [8:0] memRdata;
  instr_req_s instrReq;
  arch_state_s archLoadValue, archState, m;
  mem_req_s memReq;
  logic [8:0] mem [logic [15:0]];
  logic [57:0] expQ [$];
  logic [24:0] wrQ [$];
  logic [15:0] r = 16'he158;
  int num_errors = 0;
  int total_checks = 0;
  stack_pop_instruction_unit u_stack_pop_instruction_unit (.clk(clk), .reset(reset),
    .ce(ce), .instrReq(instrReq), .archLoad(archLoad), .archLoadValue(archLoadValue),
    .memRdata(memRdata), .memReq(memReq), .archState(archState), .busy(busy),
    .done(done), .illegal(illegal), .cyclesUsed(cyclesUsed));
  function automatic logic [15:0] rnd();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction : rnd
  // stack contents appear on first use, so the model and the memory agree
  function automatic logic [8:0] rd(input logic [15:0] a);
    logic [15:0] v;
    v = rnd();
    if (!mem.exists(a)) mem[a] = v[8:0];
    return mem[a];
  endfunction : rd
  task automatic chk_st(input logic [57:0] g, e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk_st
  task automatic chk_wr(input logic [24:0] g, e);
    chk_st({33'h0, g}, {33'h0, e});
  endtask : chk_wr
  task automatic results();
    // results that never appeared count together as one mismatch
    if (expQ.size() != 0 || wrQ.size() != 0) num_errors++;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // fixed latency puts the next start one cycle after the done cycle, two cycles after it for the pair pop
  task automatic issue(input logic [7:0] op, o1, o2, input int lat, dec, inc, cyc);
    m.sp = m.sp - 16'(dec);
    m.pc = m.pc + 16'(inc);
    if (lat > 2) expQ.push_back({m, 2'(cyc)});
    @(posedge clk);
    instrReq <= {1'b1, op, o1, o2};
    @(posedge clk);
    instrReq.start <= 1'b0;
    repeat (lat - 1) @(posedge clk);
  endtask : issue
  task automatic pop(input int k);
    logic [15:0] s, d, p;
    logic [8:0] lo, hi, pl, ph;
    s = m.sp;
    d = rnd();
    hi = rd(s);
    lo = rd(s - 16'h1);
    case (k)
      0: begin
        wrQ.push_back({d, hi});
        m.program_status_word[1] = hi[8];
        issue(8'h76, d[7:0], d[15:8], 4, 1, 3, 2);
        mem[d] = hi;
      end
      1: begin
        m.ba = {hi[7:0], lo[7:0]};
        m.program_status_word[1] = hi[8];
        issue(8'h70, d[7:0], d[15:8], 6, 2, 1, 2);
      end
      2: begin
        m.program_status_word = hi[7:0];
        issue(8'h90, d[7:0], d[15:8], 4, 1, 1, 1);
      end
      3: begin
        ph = rd({9'h0, d[5:0], 1'b1});
        pl = rd({9'h0, d[5:0], 1'b0});
        p = {ph[7:0], pl[7:0]};
        wrQ.push_back({p, lo});
        wrQ.push_back({p + 16'h1, hi});
        m.program_status_word[1] = hi[8];
        issue(8'h37, {1'b0, d[5:0], 1'b0}, d[15:8], 8, 2, 2, 3);
        mem[p] = lo;
        mem[p + 16'h1] = hi;
      end
      default: issue(8'h37, d[8] ? {1'b1, d[6:0]} : {d[7:1], 1'b1}, d[15:8], 2, 0, 0, 0);
    endcase
  endtask : pop
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // memory answers one cycle after a read; between reads the data line toggles
  always @(posedge clk) begin
    memRdata <= memReq.rd ? mem[memReq.addr] : ~memRdata;
  end
  always @(posedge clk) begin
    if (memReq.wr === 1'b1) begin
      // the memory model takes expected writes after each pop, never the outputs
      chk_wr({memReq.addr, memReq.wdata}, wrQ.pop_front());
    end
    if (done === 1'b1) chk_st({archState, cyclesUsed}, expQ.pop_front());
  end
  initial begin
    #5000;
    num_errors++;
    results();
  end
  initial begin
    reset = 1'b1;
    archLoad = 1'b0;
    instrReq = '0;
    archLoadValue = '0;
    memRdata = 9'h0;
    ce = 1'b1;
    m = {rnd(), rnd(), r[7:0], rnd()};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    archLoad <= 1'b1;
    archLoadValue <= m;
    @(posedge clk);
    archLoad <= 1'b0;
    for (int i = 0; i < 25; i++) begin
      pop(i % 5);
      $display("test %0d done", i);
      if (i % 5 == 4) begin
        // a load while frozen must not land; the next done compares the state
        ce <= 1'b0;
        archLoad <= 1'b1;
        archLoadValue <= ~m;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        archLoad <= 1'b0;
      end
    end
    repeat (4) @(posedge clk);
    results();
  end
endmodule : tb_stack_pop_instruction_unit
